// ===== src/uart_tx_pkg.sv
// Shared constants and types for the fractional baud generator and transmitter
package uart_tx_pkg;

  // Sampling mode codes in bits 5:4 of the divisor fraction value
  localparam logic [1:0] MODE_16X = 2'h0;
  localparam logic [1:0] MODE_8X  = 2'h1;
  localparam logic [1:0] MODE_4X  = 2'h2;

  // Sampling clock periods per serial bit
  localparam logic [4:0] TICKS_16X = 5'h10;
  localparam logic [4:0] TICKS_8X  = 5'h08;
  localparam logic [4:0] TICKS_4X  = 5'h04;

  // Field positions inside the divisor fraction value
  localparam int FRAC_LSB = 0;
  localparam int FRAC_W   = 4;
  localparam int MODE_LSB = 4;

  // Prescaler divide-by-4 terminal count
  localparam logic [1:0] PRESCALE_LAST = 2'h3;

  // Values after reset
  localparam logic [1:0]  PRE_CNT_RST  = 2'h0;
  localparam logic [16:0] PERIOD_RST   = 17'h00001;
  localparam logic [16:0] BAUD_CNT_RST = 17'h00001;
  localparam logic [3:0]  FRAC_ACC_RST = 4'h0;
  localparam logic [4:0]  SUB_CNT_RST  = 5'h00;
  localparam logic [2:0]  BITS_RST     = 3'h0;
  localparam logic [7:0]  SHIFT_RST    = 8'h00;

  // Line control fields sampled at the start of every frame
  typedef struct packed {
    logic [1:0] word_len;    // 0..3 selects 5..8 data bits
    logic       stop_two;    // 1: two stop bits
    logic       parity_en;   // 1: parity bit follows the data
    logic       parity_even; // 1: even parity, 0: odd parity
  } line_ctrl_t;

  localparam line_ctrl_t LINE_CTRL_RST = 5'h00;

  typedef enum logic [4:0] {
    TX_IDLE   = 5'h01,
    TX_START  = 5'h02,
    TX_DATA   = 5'h04,
    TX_PARITY = 5'h08,
    TX_STOP   = 5'h10
  } tx_state_t;

endpackage

// ===== src/uart_frac_baud_and_transmitter.sv
// Transmit FIFO plus fractional baud generator and serial transmitter
`timescale 1ns/10ps

module tx_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             i_mclk,    // Clock
  input  wire logic             i_nrst,    // Sync reset, active low
  input  wire logic             i_single,  // Hold at most one entry
  input  wire logic             i_valid,   // Write request
  input  wire logic [WIDTH-1:0] i_data,    // Write data
  output logic                  o_ready,   // Write would be taken
  output logic                  o_valid,   // Head entry present
  output logic      [WIDTH-1:0] o_data,    // Head entry
  input  wire logic             i_ready    // Head entry consumed
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  assign push = i_valid && o_ready;
  assign pop  = i_ready && o_valid;
  assign o_data = mem[rd_ptr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_data;
    end
  end

  // Pointer wrap assumes a power-of-two depth
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
    end
  end

  // Flags registered from the next count so they are honest at once
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_ready <= 1'b0;
      o_valid <= 1'b0;
    end else begin
      o_ready <= i_single ? (count_next == '0) : (count_next != (AW+1)'(DEPTH));
      o_valid <= (count_next != '0);
    end
  end
endmodule

// Overview of operation
// R1: Fraction field bits 5:4 pick 16X, 8X or 4X sampling clock.
// R2: Sampling clock is prescaled clock divided by integer plus fraction sixteenths.
// R3: Integer divisor is 16 bits, high byte and low byte inputs.
// R4: Software programs fraction as rounded sixteenths of the required divisor.
// R5: In 4X mode odd nonzero fractions may jitter the bit by one eighth.
// R6: Shift register of 8 bits fed from a 64-byte FIFO behind holding register.
// R7: A bit lasts 16, 8 or 4 sampling periods per mode.
// R8: Frame is start, data bits, optional parity, then stop bits.
// R9: Data leaves least significant bit first.
// R10: With FIFO enabled every holding write stores and advances the write pointer; here a write while the FIFO is full is refused (o_holding_ready low).
// R11: Without FIFO the host writes one byte and waits for empty.
// R12: Holding-empty flag sets when the held byte moves into the shifter.
// R13: Transmit-empty interrupt follows holding-empty only while its enable is set.
// R14: Shifter-empty flag sets once the last stop bit has gone.
// R15: Modem control bit 7 selects a prescaler of 1 or 4.
// R16: In 8X mode odd nonzero fractions may jitter the bit by one sixteenth.
// R17: Fraction is four low bits; divisor of zero acts as one.
// R18: Line control fields come from outside and are sampled per frame.
module uart_frac_baud_and_transmitter #(
  parameter int FIFO_DEPTH = 64
) (
  input  wire logic                   i_mclk,          // Crystal or external clock
  input  wire logic                   i_nrst,          // Sync reset, active low
  input  wire logic                   i_holding_wr,    // Write strobe, tx_holding
  input  wire logic [7:0]             i_holding_data,  // Byte for tx_holding
  input  wire logic [7:0]             i_divisor_low,   // Divisor low byte
  input  wire logic [7:0]             i_divisor_high,  // Divisor high byte
  input  wire logic [7:0]             i_divisor_frac,  // Fraction and mode
  input  wire logic                   i_prescale_div4, // modem_control bit 7
  input  wire logic                   i_fifo_enable,   // fifo_control bit 0
  input  wire logic                   i_tx_int_enable, // interrupt_enable bit 1
  input  wire uart_tx_pkg::line_ctrl_t i_line_ctrl,    // Frame format
  output logic                        o_holding_ready, // Holding write accepted
  output logic                        o_txd,           // Serial output
  output logic                        o_holding_empty, // line_status bit 5
  output logic                        o_shifter_empty, // line_status bit 6
  output logic                        o_tx_empty_int   // interrupt_status bit 1
);
  logic [1:0]  pre_cnt_reg;
  logic        pre_tick;
  logic [15:0] int_div;
  logic [15:0] int_eff;
  logic [3:0]  frac;
  logic [1:0]  mode;
  logic [16:0] period_reg;
  logic [16:0] baud_cnt_reg;
  logic [3:0]  frac_acc_reg;
  logic [4:0]  frac_sum;
  logic        samp_tick;

  assign int_div  = {i_divisor_high, i_divisor_low};                 // [R3]
  assign int_eff  = (int_div == 16'h0000) ? 16'h0001 : int_div;      // [R17]
  assign frac     = i_divisor_frac[uart_tx_pkg::FRAC_LSB +: uart_tx_pkg::FRAC_W]; // [R17]
  assign mode     = i_divisor_frac[uart_tx_pkg::MODE_LSB +: 2];      // [R1]
  assign frac_sum = {1'b0, frac_acc_reg} + {1'b0, frac};

  // Prescaler runs free; divide by 4 emits every fourth clock
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      pre_cnt_reg <= uart_tx_pkg::PRE_CNT_RST;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 2'h1;
    end
  end

  assign pre_tick = i_prescale_div4 ? (pre_cnt_reg == uart_tx_pkg::PRESCALE_LAST) : 1'b1; // [R15]
  assign samp_tick = pre_tick && (baud_cnt_reg >= period_reg);

  // Fraction carry stretches one period by one prescaled tick: average int + frac/16
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      baud_cnt_reg <= uart_tx_pkg::BAUD_CNT_RST;
      period_reg   <= uart_tx_pkg::PERIOD_RST;
      frac_acc_reg <= uart_tx_pkg::FRAC_ACC_RST;
    end else if (samp_tick) begin
      baud_cnt_reg <= uart_tx_pkg::BAUD_CNT_RST;
      frac_acc_reg <= frac_sum[3:0];                               // [R2]
      period_reg   <= {1'b0, int_eff} + {16'h0000, frac_sum[4]};   // [R2] [R5] [R16]
    end else if (pre_tick) begin
      baud_cnt_reg <= baud_cnt_reg + 17'h00001;
    end
  end

  // Checks the period loaded at a tick; a live divisor change only affects the next load
  jitter_bound_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R5] [R16]
    samp_tick |=> (period_reg == {1'b0, $past(int_eff)})
                  || (period_reg == {1'b0, $past(int_eff)} + 17'h00001))
    else $error("Sampling period outside integer divisor plus one");
  prescale_gap_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R15]
    (samp_tick && i_prescale_div4) |=> ((!samp_tick || !i_prescale_div4) [*3]))
    else $error("Divide-by-4 prescaler ticked too soon");

  // FIFO behind the holding register
  logic       f_valid;
  logic [7:0] f_data;
  logic       f_pop;

  tx_byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_mclk   (i_mclk),
    .i_nrst   (i_nrst),
    .i_single (!i_fifo_enable),   // [R11]
    .i_valid  (i_holding_wr),     // [R10]
    .i_data   (i_holding_data),
    .o_ready  (o_holding_ready),
    .o_valid  (f_valid),
    .o_data   (f_data),
    .i_ready  (f_pop)             // [R6]
  );

  fifo_advance_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R10]
    (i_fifo_enable && i_holding_wr && o_holding_ready && !f_valid) |=> f_valid)
    else $error("Accepted holding write did not reach the FIFO");

  // Transmitter
  uart_tx_pkg::tx_state_t  state_reg;
  uart_tx_pkg::line_ctrl_t lc_reg;
  logic [7:0]  shift_reg;
  logic [2:0]  bits_left_reg;
  logic        stop_left_reg;
  logic        parity_reg;
  logic [4:0]  sub_cnt_reg;
  logic [4:0]  bit_len;
  logic        bit_end;
  logic        frame_done;
  logic [7:0]  load_mask;
  logic        load;

  always_comb begin
    case (mode)
      uart_tx_pkg::MODE_8X: bit_len = uart_tx_pkg::TICKS_8X;       // [R1] [R7]
      uart_tx_pkg::MODE_4X: bit_len = uart_tx_pkg::TICKS_4X;       // [R1] [R7]
      default:              bit_len = uart_tx_pkg::TICKS_16X;      // [R1] [R7]
    endcase
  end

  assign bit_end    = samp_tick && (sub_cnt_reg == bit_len - 5'h01);
  assign frame_done = (state_reg == uart_tx_pkg::TX_STOP) && bit_end && !stop_left_reg;
  assign load       = f_valid && ((state_reg == uart_tx_pkg::TX_IDLE) || frame_done);
  assign f_pop      = load;
  assign load_mask  = 8'hFF >> (2'h3 - i_line_ctrl.word_len);

  // Sampling ticks within the current bit; restarts with each frame
  always_ff @(posedge i_mclk) begin
    if (!i_nrst || load || state_reg == uart_tx_pkg::TX_IDLE) begin
      sub_cnt_reg <= uart_tx_pkg::SUB_CNT_RST;
    end else if (bit_end) begin
      sub_cnt_reg <= uart_tx_pkg::SUB_CNT_RST;                     // [R7]
    end else if (samp_tick) begin
      sub_cnt_reg <= sub_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      state_reg     <= uart_tx_pkg::TX_IDLE;
      lc_reg        <= uart_tx_pkg::LINE_CTRL_RST;
      shift_reg     <= uart_tx_pkg::SHIFT_RST;
      bits_left_reg <= uart_tx_pkg::BITS_RST;
      stop_left_reg <= 1'b0;
      parity_reg    <= 1'b0;
      o_txd         <= 1'b1;
    end else if (load) begin
      state_reg  <= uart_tx_pkg::TX_START;                         // [R8]
      lc_reg     <= i_line_ctrl;                                   // [R18]
      shift_reg  <= f_data & load_mask;                            // [R6]
      parity_reg <= (^(f_data & load_mask)) ^ !i_line_ctrl.parity_even;
      o_txd      <= 1'b0;
    end else if (bit_end) begin
      case (state_reg)
        uart_tx_pkg::TX_START: begin
          state_reg     <= uart_tx_pkg::TX_DATA;
          bits_left_reg <= {1'b0, lc_reg.word_len} + 3'h4;
          o_txd         <= shift_reg[0];                           // [R9]
        end
        uart_tx_pkg::TX_DATA: begin
          if (bits_left_reg == 3'h0) begin
            if (lc_reg.parity_en) begin
              state_reg <= uart_tx_pkg::TX_PARITY;                 // [R8]
              o_txd     <= parity_reg;
            end else begin
              state_reg     <= uart_tx_pkg::TX_STOP;
              stop_left_reg <= lc_reg.stop_two;
              o_txd         <= 1'b1;
            end
          end else begin
            bits_left_reg <= bits_left_reg - 3'h1;
            shift_reg     <= shift_reg >> 1;                       // [R9]
            o_txd         <= shift_reg[1];
          end
        end
        uart_tx_pkg::TX_PARITY: begin
          state_reg     <= uart_tx_pkg::TX_STOP;                   // [R8]
          stop_left_reg <= lc_reg.stop_two;
          o_txd         <= 1'b1;
        end
        uart_tx_pkg::TX_STOP: begin
          if (stop_left_reg) begin
            stop_left_reg <= 1'b0;
          end else begin
            state_reg <= uart_tx_pkg::TX_IDLE;
          end
          o_txd <= 1'b1;
        end
        default: begin
          state_reg <= uart_tx_pkg::TX_IDLE;
          o_txd     <= 1'b1;
        end
      endcase
    end
  end

  start_low_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R8]
    (state_reg == uart_tx_pkg::TX_START) |-> !o_txd)
    else $error("Start bit not low");
  stop_high_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R8]
    (state_reg == uart_tx_pkg::TX_STOP || state_reg == uart_tx_pkg::TX_IDLE) |-> o_txd)
    else $error("Stop or idle line not high");
  lsb_first_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R9]
    (state_reg == uart_tx_pkg::TX_START && bit_end)
      |=> (o_txd == $past(shift_reg[0])))
    else $error("First data bit is not bit 0");
  bit_length_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R7]
    bit_end |-> (sub_cnt_reg + 5'h01 == bit_len))
    else $error("Bit ended at wrong sampling count");

  // Status flags; holding empties two cycles after the last held byte enters the shifter
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_holding_empty <= 1'b1;
      o_shifter_empty <= 1'b1;
      o_tx_empty_int  <= 1'b0;
    end else begin
      o_holding_empty <= !f_valid;                                 // [R12]
      o_shifter_empty <= !f_valid && (state_reg == uart_tx_pkg::TX_IDLE); // [R14]
      o_tx_empty_int  <= o_holding_empty && i_tx_int_enable;       // [R13]
    end
  end

  holding_empty_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R12]
    (load && !i_fifo_enable) |=> ##1 o_holding_empty)
    else $error("Holding empty not set after transfer to shifter");
  tx_int_gate_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R13]
    o_tx_empty_int |-> ($past(o_holding_empty) && $past(i_tx_int_enable)))
    else $error("Transmit-empty interrupt without flag and enable");
  // A write taken on the last stop bit starts a new frame, so it is excluded
  shifter_empty_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R14]
    (frame_done && !f_valid && !(i_holding_wr && o_holding_ready)) |=> ##1 o_shifter_empty)
    else $error("Shifter empty not set after last stop bit");
endmodule

// ===== tb/uart_rx_model.sv
// Remote receiver model that samples the serial line near mid-bit
`timescale 1ns/10ps
module uart_rx_model (
  input  wire logic        i_mclk,     // Clock
  input  wire logic        i_rxd,      // Serial line
  input  wire logic [31:0] i_bit_cyc,  // Clocks per bit
  input  wire logic [31:0] i_tick_cyc, // Clocks per sampling tick
  input  wire logic [3:0]  i_nbits,    // Data bits
  input  wire logic        i_par_en,   // Parity bit present
  input  wire logic [1:0]  i_nstop,    // Stop bits
  output logic      [7:0]  o_data,     // Last byte
  output logic             o_par,      // Last parity bit
  output logic             o_stop_ok,  // Stop bits all high
  output logic      [31:0] o_count     // Frames seen
);
  int i;
  initial begin
    o_data = 8'h00;
    o_par = 1'b0;
    o_stop_ok = 1'b0;
    o_count = 32'h0;
    forever begin
      @(negedge i_rxd);
      // Start bit may run up to one tick short, so aim early
      repeat ((i_bit_cyc - i_tick_cyc) / 2) @(negedge i_mclk);
      o_data = 8'h00;
      for (i = 0; i < i_nbits; i++) begin
        repeat (i_bit_cyc) @(negedge i_mclk);
        o_data[i] = i_rxd;
      end
      if (i_par_en) begin
        repeat (i_bit_cyc) @(negedge i_mclk);
        o_par = i_rxd;
      end
      o_stop_ok = 1'b1;
      for (i = 0; i < i_nstop; i++) begin
        repeat (i_bit_cyc) @(negedge i_mclk);
        o_stop_ok = o_stop_ok & i_rxd;
      end
      o_count = o_count + 1;
    end
  end
endmodule

// ===== tb/uart_frac_baud_and_transmitter_tb.sv
// Self-checking bench for the fractional baud generator and transmitter
`timescale 1ns/10ps
module uart_frac_baud_and_transmitter_tb;
  logic                    mclk, nrst, wr, pre4, fifo_en, int_en, par_en;
  logic [7:0]              wdata, div_lo, div_hi, div_frac, rx_data;
  uart_tx_pkg::line_ctrl_t lc;
  logic                    ready, txd, h_empty, s_empty, tx_int, rx_par, rx_stop;
  logic [31:0]             bit_cyc, tick_cyc, rx_count;
  logic [3:0]              nbits;
  logic [1:0]              nstop;
  int                      fails = 0;
  int                      cmp_count = 0;
  int                      cycles = 0;

  uart_frac_baud_and_transmitter dut (
    .i_mclk(mclk), .i_nrst(nrst), .i_holding_wr(wr), .i_holding_data(wdata),
    .i_divisor_low(div_lo), .i_divisor_high(div_hi), .i_divisor_frac(div_frac),
    .i_prescale_div4(pre4), .i_fifo_enable(fifo_en), .i_tx_int_enable(int_en),
    .i_line_ctrl(lc), .o_holding_ready(ready), .o_txd(txd), .o_holding_empty(h_empty),
    .o_shifter_empty(s_empty), .o_tx_empty_int(tx_int));
  uart_rx_model rx (
    .i_mclk(mclk), .i_rxd(txd), .i_bit_cyc(bit_cyc), .i_tick_cyc(tick_cyc),
    .i_nbits(nbits), .i_par_en(par_en), .i_nstop(nstop), .o_data(rx_data),
    .o_par(rx_par), .o_stop_ok(rx_stop), .o_count(rx_count));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Whole run needs about 25k cycles
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles > 60000) begin
      fails = fails + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Holds the write until ready is sampled high with it
  task automatic put(input logic [7:0] d);
    logic acc;
    int   k;
    k = 0;
    wr = 1'b1;
    wdata = d;
    do begin
      acc = (ready === 1'b1);
      tick(1);
      k++;
    end while (!acc && k < 20000);
    wr = 1'b0;
  endtask

  task automatic wait_frame(input logic [31:0] n);
    int k;
    k = 0;
    while (rx_count !== n && k < 20000) begin
      tick(1);
      k++;
    end
    check("frame count", rx_count, n);
  endtask

  task automatic t_reset();
    tick(10);
    check("idle line", txd, 1'b1);
    check("holding empty", h_empty, 1'b1);
    check("shifter empty", s_empty, 1'b1);
    check("int low", tx_int, 1'b0);
    nrst = 1'b1;
    tick(2);
    check("ready", ready, 1'b1);
  endtask

  // Width of the first data bit of 0x55, the first high run after the start bit
  task automatic rate(input logic [1:0] m, input logic [3:0] fr, input logic [7:0] hi,
                      input logic [7:0] lo, input logic p, input int lo_c, input int hi_c,
                      input int tk);
    int n, k;
    n = 0;
    k = 0;
    div_frac = {2'h0, m, fr};
    div_hi = hi;
    div_lo = lo;
    pre4 = p;
    bit_cyc = lo_c;
    tick_cyc = tk;
    tick(2);
    put(8'h55);
    while (txd !== 1'b0 && k < 20000) begin
      tick(1);
      k++;
    end
    while (txd !== 1'b1 && k < 20000) begin
      tick(1);
      k++;
    end
    while (txd === 1'b1 && k < 20000) begin
      tick(1);
      n++;
      k++;
    end
    check("bit length", (n >= lo_c && n <= hi_c), 1'b1);
    wait_frame(rx_count + 1);
    check("rate data", rx_data, 8'h55);
  endtask

  task automatic t_rates();
    rate(uart_tx_pkg::MODE_16X, 4'h0, 8'h00, 8'h01, 1'b0, 16, 16, 1);
    rate(uart_tx_pkg::MODE_8X, 4'h0, 8'h00, 8'h03, 1'b0, 24, 24, 3);
    rate(uart_tx_pkg::MODE_4X, 4'h0, 8'h00, 8'h02, 1'b1, 32, 32, 8);
    rate(uart_tx_pkg::MODE_4X, 4'h0, 8'h01, 8'h00, 1'b0, 1024, 1024, 256);
    rate(uart_tx_pkg::MODE_16X, 4'h8, 8'h00, 8'h02, 1'b0, 40, 40, 2);
    rate(uart_tx_pkg::MODE_8X, 4'h8, 8'h00, 8'h02, 1'b0, 20, 20, 2);
    rate(uart_tx_pkg::MODE_8X, 4'h1, 8'h00, 8'h02, 1'b0, 16, 17, 2);
    rate(uart_tx_pkg::MODE_4X, 4'h4, 8'h00, 8'h02, 1'b0, 9, 9, 2);
    rate(uart_tx_pkg::MODE_4X, 4'h1, 8'h00, 8'h02, 1'b0, 8, 9, 2);
    rate(uart_tx_pkg::MODE_8X, 4'h0, 8'h00, 8'h00, 1'b0, 8, 8, 1);
    rate(2'h3, 4'h0, 8'h00, 8'h01, 1'b0, 16, 16, 1);
  endtask

  task automatic t_format();
    rate(uart_tx_pkg::MODE_16X, 4'h0, 8'h00, 8'h01, 1'b0, 16, 16, 1);
    lc = 5'h17;
    nbits = 4'h7;
    par_en = 1'b1;
    nstop = 2'h2;
    put(8'hDB);
    tick(1);
    put(8'h80);
    wait_frame(rx_count + 1);
    check("7 bit data", rx_data, 8'h5B);
    check("even parity", rx_par, 1'b1);
    check("two stops", rx_stop, 1'b1);
    wait_frame(rx_count + 1);
    check("masked data", rx_data, 8'h00);
    check("even parity 0", rx_par, 1'b0);
    lc = 5'h02;
    nbits = 4'h5;
    nstop = 2'h1;
    put(8'hF3);
    wait_frame(rx_count + 1);
    check("5 bit data", rx_data, 8'h13);
    check("odd parity", rx_par, 1'b0);
    lc = 5'h18;
    nbits = 4'h8;
    par_en = 1'b0;
  endtask

  // Back-to-back writes until the FIFO refuses, then drain in order
  task automatic t_fifo();
    logic [7:0] q[$];
    int k;
    tick(40);
    wr = 1'b1;
    for (k = 0; k < 70; k++) begin
      wdata = 8'h30 + k[7:0];
      if (ready === 1'b1) q.push_back(wdata);
      tick(1);
    end
    wr = 1'b0;
    // 64 queued plus one already moved into the shifter
    check("fifo fill", q.size(), 65);
    check("full ready", ready, 1'b0);
    check("full not empty", h_empty, 1'b0);
    foreach (q[i]) begin
      wait_frame(rx_count + 1);
      check("fifo order", rx_data, q[i]);
    end
    tick(40);
    check("drained", h_empty, 1'b1);
    check("shifter drained", s_empty, 1'b1);
  endtask

  task automatic t_single();
    logic [31:0] n0;
    int k;
    fifo_en = 1'b0;
    int_en = 1'b1;
    n0 = rx_count;
    tick(2);
    put(8'hC6);
    tick(1);
    check("held", h_empty, 1'b0);
    k = 0;
    while (h_empty !== 1'b1 && k < 8) begin
      tick(1);
      k++;
    end
    check("empty on load", h_empty, 1'b1);
    check("start bit", txd, 1'b0);
    check("shifter busy", s_empty, 1'b0);
    tick(2);
    check("int raised", tx_int, 1'b1);
    int_en = 1'b0;
    tick(2);
    check("int masked", tx_int, 1'b0);
    put(8'h3A);
    tick(1);
    check("second held", h_empty, 1'b0);
    wait_frame(n0 + 1);
    check("first byte", rx_data, 8'hC6);
    wait_frame(n0 + 2);
    check("second byte", rx_data, 8'h3A);
    tick(40);
    check("all sent", s_empty, 1'b1);
    int_en = 1'b1;
    tick(2);
    check("int again", tx_int, 1'b1);
  endtask

  initial begin
    nrst = 1'b0;
    wr = 1'b0;
    wdata = 8'h00;
    div_lo = 8'h01;
    div_hi = 8'h00;
    div_frac = 8'h00;
    pre4 = 1'b0;
    fifo_en = 1'b1;
    int_en = 1'b0;
    lc = 5'h18;
    bit_cyc = 16;
    tick_cyc = 1;
    nbits = 4'h8;
    par_en = 1'b0;
    nstop = 2'h1;
    t_reset();
    t_rates();
    t_format();
    t_fifo();
    t_single();
    stop_test();
  end
endmodule
